// >>> src/xbus_addr_decode.sv
`timescale 1ns/100ps
`include "xbus_params.svh"

module xbus_addr_decode (
    input  wire logic [9:0]          addr,
    output xbus_pkg::host_sel_t      sel
);
    import xbus_pkg::*;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] base,
                                 input logic [9:0] mask);
        hit = ((a ^ base) & mask) == 10'h000;
    endfunction

    // All ten bits take part, so aliases above the map stay unselected
    always_comb begin
        sel.unit = UNIT_NONE;
        sel.idx  = 8'h00;
        if (hit(addr, `XB_DMA_LO_BASE, `XB_DMA_LO_MASK)) begin
            sel.unit = UNIT_DMA_LO;
            sel.idx  = {4'h0, addr[3:0]};
        end else if (hit(addr, `XB_DMA_HI_BASE, `XB_DMA_HI_MASK)) begin
            sel.unit = UNIT_DMA_HI;
            sel.idx  = {4'h0, addr[4:1]};
        end else if (hit(addr, `XB_INTC_M_BASE, `XB_INTC_M_MASK)) begin
            sel.unit = UNIT_INTC_M;
            sel.idx  = {7'h00, addr[0]};
        end else if (hit(addr, `XB_CFG_BASE, `XB_CFG_MASK)) begin
            sel.unit = UNIT_CFG;
            sel.idx  = {7'h00, addr[0]};
        end else if (hit(addr, `XB_TIMER_BASE, `XB_TIMER_MASK)) begin
            sel.unit = UNIT_TIMER;
            sel.idx  = {6'h00, addr[1:0]};
        end else if (hit(addr, `XB_RTC_BASE, `XB_RTC_MASK)) begin
            sel.unit = addr[0] ? UNIT_RTC_DATA : UNIT_RTC_IDX;
            sel.idx  = 8'h00;
        end else if (hit(addr, `XB_PAGE_BASE, `XB_PAGE_MASK)) begin
            sel.unit = UNIT_PAGE;
            sel.idx  = {4'h0, addr[3:0]};
        end else if (hit(addr, `XB_INTC_S_BASE, `XB_INTC_S_MASK)) begin
            sel.unit = UNIT_INTC_S;
            sel.idx  = {7'h00, addr[0]};
        end
    end

endmodule // xbus_addr_decode

// >>> src/xbus_host_port.sv
`timescale 1ns/100ps
`include "xbus_params.svh"

// Function
// - host read drives selected register onto data
// - host write captures data into register
// - DMA drives upper address byte, latch strobed
// - memory-to-memory read stores data in temp
// - memory-to-memory write drives temp onto data
// - interrupt acknowledge drives vector byte onto data
// - clock/RAM access: address first, then data
// - low nine address pins bidirectional, top input
// - decode all ten address bits for units
// - low DMA channels use address bits 3..0
// - high DMA channels use bits 4..1
// - byte DMA drives address pins 7..0
// - word DMA drives pins 8..1, pin 0 free
// - read strobe is host input outside DMA
// - DMA write-memory drives read strobe itself
// - data pins driven only when sourcing, else released
// - write strobe input, driven in DMA read-memory
module xbus_host_port #(
    parameter int DATA_W = 8
) (
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    input  wire logic [7:0]          system_data_pins_in,
    output logic [7:0]               system_data_pins_out,
    output logic                     system_data_pins_oe_n,
    input  wire logic [8:0]          low_address_pins_in,
    output logic [8:0]               low_address_pins_out,
    output logic [8:0]               low_address_pins_oe_n,
    input  wire logic                top_address_pin,
    input  wire logic                io_read_strobe_n_in,
    output logic                     io_read_strobe_n_out,
    output logic                     io_read_strobe_n_oe_n,
    input  wire logic                io_write_strobe_n_in,
    output logic                     io_write_strobe_n_out,
    output logic                     io_write_strobe_n_oe_n,
    output logic                     upper_addr_strobe_byte_chan,
    output logic                     upper_addr_strobe_word_chan,
    input  wire xbus_pkg::dma_ctl_t  dma_ctl,
    input  wire logic                inta_active,
    input  wire logic [7:0]          inta_vector,
    input  wire logic [7:0]          host_rd_data,
    output xbus_pkg::host_req_t      host_req,
    output logic [7:0]               temp_data
);
    import xbus_pkg::*;

    initial begin
        if (DATA_W != 8) begin
            $error("xbus_host_port serves an 8-bit data bus only");
        end
    end

    // Pin synchroniser: {top addr, low addr, data, read_n, write_n}
    logic [19:0]    pin_meta_ff;
    logic [19:0]    pin_sync_ff;
    logic [7:0]     d_in;
    logic [9:0]     a_in;
    logic           rd_n_s;
    logic           wr_n_s;
    logic           rd_prev_ff;
    logic           wr_prev_ff;
    logic [3:0]     own_hist_ff;
    logic           host_ok;
    logic           rd_start;
    logic           wr_end;
    host_sel_t      dec_sel;
    host_sel_t      eff_sel;
    logic           rd_active_ff;
    logic [7:0]     rtc_index_ff;
    logic [7:0]     temp_ff;
    host_req_t      host_req_ff;
    logic [7:0]     data_out_ff;
    logic [7:0]     nxt_data_out;
    logic           data_oe_n_ff;
    logic           nxt_data_oe_n;
    logic [8:0]     addr_out_ff;
    logic [8:0]     nxt_addr_out;
    logic [8:0]     addr_oe_n_ff;
    logic [8:0]     nxt_addr_oe_n;
    logic           rd_out_ff;
    logic           wr_out_ff;
    logic           strb_oe_n_ff;
    logic           stb_byte_ff;
    logic           stb_word_ff;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_ff <= 20'h00003;
            pin_sync_ff <= 20'h00003;
        end else begin
            pin_meta_ff <= {top_address_pin, low_address_pins_in, system_data_pins_in,
                            io_read_strobe_n_in, io_write_strobe_n_in};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign a_in   = pin_sync_ff[19:10];
    assign d_in   = pin_sync_ff[9:2];
    assign rd_n_s = pin_sync_ff[1];
    assign wr_n_s = pin_sync_ff[0];

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_prev_ff <= 1'b1;
            wr_prev_ff <= 1'b1;
        end else begin
            rd_prev_ff <= rd_n_s;
            wr_prev_ff <= wr_n_s;
        end
    end

    // Our own strobes echo through the synchroniser for four edges after
    // release, so host decoding stays masked until the echo has passed
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            own_hist_ff <= 4'h0;
        end else begin
            own_hist_ff <= {own_hist_ff[2:0], dma_ctl.own};
        end
    end

    assign host_ok  = !dma_ctl.own && !inta_active && own_hist_ff == 4'h0;
    assign rd_start = host_ok && rd_prev_ff && !rd_n_s;
    assign wr_end   = host_ok && !wr_prev_ff && wr_n_s;

    xbus_addr_decode u_decode (
        .addr (a_in),
        .sel  (dec_sel)
    );

    // The data port of the clock/RAM reaches the location chosen by
    // the index byte written beforehand
    always_comb begin
        eff_sel = dec_sel;
        if (dec_sel.unit == UNIT_RTC_DATA) begin
            eff_sel.idx = rtc_index_ff;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rtc_index_ff <= `XB_IDX_RST;
        end else if (wr_end && dec_sel.unit == UNIT_RTC_IDX) begin
            rtc_index_ff <= d_in;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_active_ff <= 1'b0;
        end else if (rd_start && dec_sel.unit != UNIT_NONE) begin
            rd_active_ff <= 1'b1;
        end else if (rd_n_s || !host_ok) begin
            rd_active_ff <= 1'b0;
        end
    end

    // Write data is taken at the trailing edge, when the host has
    // certainly settled it on the bus
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_req_ff <= '0;
        end else begin
            host_req_ff.rd <= rd_start && dec_sel.unit != UNIT_NONE;
            host_req_ff.wr <= wr_end && dec_sel.unit != UNIT_NONE;
            if (rd_start || wr_end) begin
                host_req_ff.sel   <= eff_sel;
                host_req_ff.wdata <= d_in;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            temp_ff <= `XB_DATA_RST;
        end else if (dma_ctl.own && dma_ctl.m2m_cap) begin
            temp_ff <= d_in;
        end
    end

    // Data pin source, highest priority first
    always_comb begin
        nxt_data_out  = `XB_DATA_RST;
        nxt_data_oe_n = 1'b1;
        if (dma_ctl.own) begin
            if (dma_ctl.m2m_drive) begin
                nxt_data_out  = temp_ff;
                nxt_data_oe_n = 1'b0;
            end else if (dma_ctl.drive_hi) begin
                nxt_data_out  = dma_ctl.addr_hi;
                nxt_data_oe_n = 1'b0;
            end
        end else if (inta_active) begin
            nxt_data_out  = inta_vector;
            nxt_data_oe_n = 1'b0;
        end else if (rd_active_ff) begin
            nxt_data_out  = host_rd_data;
            nxt_data_oe_n = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_out_ff  <= `XB_DATA_RST;
            data_oe_n_ff <= 1'b1;
        end else begin
            data_out_ff  <= nxt_data_out;
            data_oe_n_ff <= nxt_data_oe_n;
        end
    end

    // Address pins; top pin has no driver at all
    always_comb begin
        nxt_addr_out  = `XB_ADDR_RST;
        nxt_addr_oe_n = `XB_ADDR_OFF_N;
        if (dma_ctl.own && dma_ctl.word_chan) begin
            nxt_addr_out  = {dma_ctl.addr_lo, 1'b0};
            nxt_addr_oe_n = `XB_ADDR_WORD_N;
        end else if (dma_ctl.own) begin
            nxt_addr_out  = {1'b0, dma_ctl.addr_lo};
            nxt_addr_oe_n = `XB_ADDR_BYTE_N;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_out_ff  <= `XB_ADDR_RST;
            addr_oe_n_ff <= `XB_ADDR_OFF_N;
        end else begin
            addr_out_ff  <= nxt_addr_out;
            addr_oe_n_ff <= nxt_addr_oe_n;
        end
    end

    // Strobes turn to outputs only while we own the bus; idle level is
    // high so release never glitches a strobe low
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_out_ff    <= 1'b1;
            wr_out_ff    <= 1'b1;
            strb_oe_n_ff <= 1'b1;
        end else begin
            rd_out_ff    <= !(dma_ctl.own && dma_ctl.io_rd);
            wr_out_ff    <= !(dma_ctl.own && dma_ctl.io_wr);
            strb_oe_n_ff <= !dma_ctl.own;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stb_byte_ff <= 1'b0;
            stb_word_ff <= 1'b0;
        end else begin
            stb_byte_ff <= dma_ctl.own && dma_ctl.addr_stb && !dma_ctl.word_chan;
            stb_word_ff <= dma_ctl.own && dma_ctl.addr_stb && dma_ctl.word_chan;
        end
    end

    assign system_data_pins_out        = data_out_ff;
    assign system_data_pins_oe_n       = data_oe_n_ff;
    assign low_address_pins_out        = addr_out_ff;
    assign low_address_pins_oe_n       = addr_oe_n_ff;
    assign io_read_strobe_n_out        = rd_out_ff;
    assign io_read_strobe_n_oe_n       = strb_oe_n_ff;
    assign io_write_strobe_n_out       = wr_out_ff;
    assign io_write_strobe_n_oe_n      = strb_oe_n_ff;
    assign upper_addr_strobe_byte_chan = stb_byte_ff;
    assign upper_addr_strobe_word_chan = stb_word_ff;
    assign host_req                    = host_req_ff;
    assign temp_data                   = temp_ff;

    AST_HOST_READ_DRIVE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (rd_active_ff && host_ok) |=>
            (!system_data_pins_oe_n && system_data_pins_out == $past(host_rd_data)))
        else $error("host read data not driven");

    AST_HOST_WRITE_CAPTURE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr_end && dec_sel.unit != UNIT_NONE) |=>
            (host_req.wr && host_req.wdata == $past(d_in) && system_data_pins_oe_n))
        else $error("host write not captured");

    AST_UPPER_BYTE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dma_ctl.own && dma_ctl.drive_hi && !dma_ctl.m2m_drive) |=>
            (!system_data_pins_oe_n && system_data_pins_out == $past(dma_ctl.addr_hi)))
        else $error("upper address byte missing");

    AST_TEMP_CAPTURE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dma_ctl.own && dma_ctl.m2m_cap) |=> (temp_data == $past(d_in)))
        else $error("temporary register not loaded");

    AST_TEMP_DRIVE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dma_ctl.own && dma_ctl.m2m_drive) |=>
            (!system_data_pins_oe_n && system_data_pins_out == $past(temp_data)))
        else $error("temporary data not driven");

    AST_VECTOR: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!dma_ctl.own && inta_active) |=>
            (!system_data_pins_oe_n && system_data_pins_out == $past(inta_vector)))
        else $error("interrupt vector not driven");

    AST_RTC_INDEX: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ((rd_start || wr_end) && dec_sel.unit == UNIT_RTC_DATA)
            |=> (host_req.sel.idx == $past(rtc_index_ff)))
        else $error("clock data access lost its index");

    AST_WORD_ADDR: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dma_ctl.own && dma_ctl.word_chan) |=>
            (low_address_pins_oe_n == 9'h001
             && low_address_pins_out[8:1] == $past(dma_ctl.addr_lo)))
        else $error("word channel address wrong");

    AST_BYTE_ADDR: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dma_ctl.own && !dma_ctl.word_chan) |=>
            (low_address_pins_out[7:0] == $past(dma_ctl.addr_lo)
             && low_address_pins_oe_n == 9'h100))
        else $error("byte channel address wrong");

    AST_DATA_RELEASE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!dma_ctl.own && !inta_active && !rd_active_ff) |=> system_data_pins_oe_n)
        else $error("data pins driven without source");

    AST_DMA_READ_STROBE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dma_ctl.own && dma_ctl.io_rd) |=> (!io_read_strobe_n_out && !io_read_strobe_n_oe_n))
        else $error("read strobe not driven in DMA");

    AST_DMA_WRITE_STROBE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dma_ctl.own && dma_ctl.io_wr) |=> (!io_write_strobe_n_out && !io_write_strobe_n_oe_n))
        else $error("write strobe not driven in DMA");

    AST_RELEASE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !dma_ctl.own |=> (io_read_strobe_n_oe_n && io_write_strobe_n_oe_n
                          && low_address_pins_oe_n == 9'h1FF))
        else $error("pins still driven after ownership");

    AST_NO_HOST_IN_DMA: assert property (@(posedge sys_clk) disable iff (sys_rst)
        dma_ctl.own |=> (!host_req.rd && !host_req.wr))
        else $error("host access taken during DMA");

endmodule // xbus_host_port

// >>> src/xbus_params.svh
`ifndef XBUS_PARAMS_SVH
`define XBUS_PARAMS_SVH

// Host I/O port map: base, compare mask (1 = bit must match)
`define XB_DMA_LO_BASE   10'h000
`define XB_DMA_LO_MASK   10'h3F0
`define XB_INTC_M_BASE   10'h020
`define XB_INTC_M_MASK   10'h3FE
`define XB_CFG_BASE      10'h022
`define XB_CFG_MASK      10'h3FE
`define XB_TIMER_BASE    10'h040
`define XB_TIMER_MASK    10'h3FC
`define XB_RTC_BASE      10'h070
`define XB_RTC_MASK      10'h3FE
`define XB_PAGE_BASE     10'h080
`define XB_PAGE_MASK     10'h3F0
`define XB_INTC_S_BASE   10'h0A0
`define XB_INTC_S_MASK   10'h3FE
`define XB_DMA_HI_BASE   10'h0C0
`define XB_DMA_HI_MASK   10'h3E0

// Reset values of the pin drivers, DMA address pin enables and clock/RAM index reset
`define XB_DATA_RST      8'h00
`define XB_ADDR_RST      9'h000
`define XB_ADDR_OFF_N    9'h1FF
`define XB_ADDR_BYTE_N   9'h100
`define XB_ADDR_WORD_N   9'h001
`define XB_IDX_RST       8'h00

`endif

// >>> src/xbus_pkg.sv
package xbus_pkg;

    typedef enum logic [3:0] {
        UNIT_NONE     = 4'h0,
        UNIT_CFG      = 4'h1,
        UNIT_DMA_LO   = 4'h2,
        UNIT_DMA_HI   = 4'h3,
        UNIT_INTC_M   = 4'h4,
        UNIT_INTC_S   = 4'h5,
        UNIT_TIMER    = 4'h6,
        UNIT_RTC_IDX  = 4'h7,
        UNIT_RTC_DATA = 4'h8,
        UNIT_PAGE     = 4'h9
    } unit_t;

    typedef struct packed {
        unit_t      unit;
        logic [7:0] idx;
    } host_sel_t;

    typedef struct packed {
        host_sel_t  sel;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic       own;
        logic       word_chan;
        logic       io_rd;
        logic       io_wr;
        logic       addr_stb;
        logic       drive_hi;
        logic       m2m_cap;
        logic       m2m_drive;
        logic [7:0] addr_lo;
        logic [7:0] addr_hi;
    } dma_ctl_t;

endpackage

// >>> test/host_bus_model.sv
`timescale 1ns/100ps
module host_bus_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    input  wire logic [8:0] addr_out,
    input  wire logic [8:0] addr_oe_n,
    input  wire logic       rd_out,
    input  wire logic       rd_oe_n,
    input  wire logic       wr_out,
    input  wire logic       wr_oe_n,
    input  wire logic       stb_byte,
    input  wire logic       stb_word,
    output logic      [7:0] data_level,
    output logic      [8:0] addr_level,
    output logic            top_addr,
    output logic            rd_level,
    output logic            wr_level,
    output logic      [7:0] latched_hi
);
    logic [7:0] drv_data;
    logic [7:0] last_data;
    logic [8:0] last_addr;
    logic [9:0] drv_addr;
    logic       drv_data_en;
    logic       drv_addr_en;
    logic       rd_n;
    logic       wr_n;

    initial begin
        drv_data = 8'h00;
        drv_addr = 10'h000;
        drv_data_en = 1'b0;
        drv_addr_en = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        last_data = 8'hA5;
        last_addr = 9'h0A5;
        latched_hi = 8'h00;
    end

    // Undriven data and low address lines show the inverse of their last level so a stale value never matches
    assign data_level = !data_oe_n ? data_out : (drv_data_en ? drv_data : ~last_data);
    assign addr_level = (addr_out & ~addr_oe_n)
                      | ((drv_addr_en ? drv_addr[8:0] : ~last_addr) & addr_oe_n);
    assign top_addr = drv_addr[9];
    // Strobes have pull-ups; the host lets go of them while the device owns the bus
    assign rd_level = !rd_oe_n ? rd_out : rd_n;
    assign wr_level = !wr_oe_n ? wr_out : wr_n;

    always @(posedge sys_clk) begin
        if (!data_oe_n || drv_data_en) begin
            last_data <= data_level;
        end
        last_addr <= addr_level;
        if (stb_byte | stb_word) begin
            latched_hi <= data_level;
        end
    end

    task automatic start_cycle(input logic wr, input logic [9:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        drv_addr = a;
        drv_addr_en = 1'b1;
        drv_data = d;
        drv_data_en = wr;
        @(negedge sys_clk);
        if (wr) begin
            wr_n = 1'b0;
        end else begin
            rd_n = 1'b0;
        end
    endtask

    // Data held past the synchronised rising strobe, then a gap of more than two clocks
    task automatic end_cycle();
        @(negedge sys_clk);
        rd_n = 1'b1;
        wr_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        drv_data_en = 1'b0;
        drv_addr_en = 1'b0;
    endtask

    task automatic mem_data(input logic en, input logic [7:0] d);
        @(negedge sys_clk);
        drv_data = d;
        drv_data_en = en;
    endtask
endmodule // host_bus_model

// >>> test/xbus_host_port_bench.sv
`timescale 1ns/100ps
module xbus_host_port_bench;
    import xbus_pkg::*;
    logic        sys_clk, sys_rst, inta_active, data_oe_n, top_addr;
    logic        rd_out, rd_oe_n, rd_level, wr_out, wr_oe_n, wr_level, stb_byte, stb_word;
    logic [7:0]  inta_vector, host_rd_data, data_out, temp_data, data_level, latched_hi;
    logic [7:0]  rtc_idx;
    logic [8:0]  addr_out, addr_oe_n, addr_level;
    logic [31:0] rnd;
    dma_ctl_t    dma_ctl;
    host_req_t   host_req;
    int          failures, check_count;
    logic [9:0]  addrs [12] = '{10'h000, 10'h00F, 10'h010, 10'h021, 10'h023, 10'h043,
                                10'h08F, 10'h0A1, 10'h0C0, 10'h0DF, 10'h0E0, 10'h222};

    xbus_host_port i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .system_data_pins_in(data_level), .system_data_pins_out(data_out),
        .system_data_pins_oe_n(data_oe_n), .low_address_pins_in(addr_level),
        .low_address_pins_out(addr_out), .low_address_pins_oe_n(addr_oe_n),
        .top_address_pin(top_addr), .io_read_strobe_n_in(rd_level),
        .io_read_strobe_n_out(rd_out), .io_read_strobe_n_oe_n(rd_oe_n),
        .io_write_strobe_n_in(wr_level), .io_write_strobe_n_out(wr_out),
        .io_write_strobe_n_oe_n(wr_oe_n), .upper_addr_strobe_byte_chan(stb_byte),
        .upper_addr_strobe_word_chan(stb_word), .dma_ctl(dma_ctl),
        .inta_active(inta_active), .inta_vector(inta_vector),
        .host_rd_data(host_rd_data), .host_req(host_req), .temp_data(temp_data));

    host_bus_model i_host (.sys_clk(sys_clk), .data_out(data_out), .data_oe_n(data_oe_n),
        .addr_out(addr_out), .addr_oe_n(addr_oe_n), .rd_out(rd_out), .rd_oe_n(rd_oe_n),
        .wr_out(wr_out), .wr_oe_n(wr_oe_n), .stb_byte(stb_byte), .stb_word(stb_word),
        .data_level(data_level), .addr_level(addr_level), .top_addr(top_addr),
        .rd_level(rd_level), .wr_level(wr_level), .latched_hi(latched_hi));

    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    function automatic unit_t exp_unit(input logic [9:0] a);
        if (a[9:4] == 6'h00) return UNIT_DMA_LO;
        if (a[9:1] == 9'h010) return UNIT_INTC_M;
        if (a[9:1] == 9'h011) return UNIT_CFG;
        if (a[9:2] == 8'h10) return UNIT_TIMER;
        if (a == 10'h070) return UNIT_RTC_IDX;
        if (a == 10'h071) return UNIT_RTC_DATA;
        if (a[9:4] == 6'h08) return UNIT_PAGE;
        if (a[9:1] == 9'h050) return UNIT_INTC_S;
        if (a[9:5] == 5'h06) return UNIT_DMA_HI;
        return UNIT_NONE;
    endfunction

    // Top bit flags whether the index is checked for that unit
    function automatic logic [8:0] exp_idx(input logic [9:0] a);
        if (exp_unit(a) == UNIT_DMA_LO) return {5'h10, a[3:0]};
        if (exp_unit(a) == UNIT_DMA_HI) return {5'h10, a[4:1]};
        if (exp_unit(a) == UNIT_RTC_DATA) return {1'b1, rtc_idx};
        return 9'h000;
    endfunction

    function automatic void roll();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    endfunction

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_unit(input unit_t exp, input unit_t got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED unit expected %h seen %h", exp, got);
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s done, failures so far %0d", name, failures);
    endtask

    task automatic host_access(input logic wr, input logic [9:0] a, input logic [7:0] d,
                               input logic allowed);
        int         pulses;
        host_req_t  seen;
        logic       ok;
        pulses = 0;
        seen = '0;
        ok = allowed && (exp_unit(a) != UNIT_NONE);
        host_rd_data = d;
        i_host.start_cycle(wr, a, d);
        fork
            if (wr) i_host.end_cycle();
            repeat (8) begin
                @(negedge sys_clk);
                if (host_req.rd | host_req.wr) begin
                    pulses++;
                    seen = host_req;
                end
            end
        join
        check_val("request pulses", {31'h0, ok}, pulses);
        if (ok) begin
            check_unit(exp_unit(a), seen.sel.unit);
            if (exp_idx(a) & 9'h100) check_val("index", exp_idx(a) & 9'h0FF, seen.sel.idx);
            check_val("kind", {wr, !wr}, {seen.wr, seen.rd});
            if (wr) check_val("write data", d, seen.wdata);
            if (!wr) check_val("read data", {1'b0, d}, {data_oe_n, data_level});
            if (wr && exp_unit(a) == UNIT_RTC_IDX) rtc_idx = d;
        end else if (!inta_active) begin
            check_val("refused drive", 1, data_oe_n);
        end
        if (!wr) i_host.end_cycle();
        if (!inta_active) check_val("data release", 1, data_oe_n);
    endtask

    task automatic dma_check(input logic word, input logic to_mem);
        dma_ctl_t c;
        logic     echo = 1'b0;
        roll();
        c = '{own: 1'b1, word_chan: word, io_rd: to_mem, io_wr: !to_mem, addr_stb: 1'b1,
              drive_hi: 1'b1, m2m_cap: 1'b0, m2m_drive: 1'b0, addr_lo: rnd[7:0],
              addr_hi: rnd[15:8]};
        @(negedge sys_clk);
        dma_ctl = c;
        @(negedge sys_clk);
        check_val("upper byte", {1'b0, c.addr_hi}, {data_oe_n, data_level});
        check_val("addr enables", word ? 9'h001 : 9'h100, addr_oe_n);
        check_val("addr", c.addr_lo, word ? addr_level[8:1] : addr_level[7:0]);
        check_val("strobes", {!to_mem, to_mem, 2'b00, !word, word},
                  {rd_level, wr_level, rd_oe_n, wr_oe_n, stb_byte, stb_word});
        @(negedge sys_clk);
        check_val("latched byte", c.addr_hi, latched_hi);
        dma_ctl = '0;
        repeat (6) begin
            @(negedge sys_clk);
            echo |= host_req.rd | host_req.wr;
        end
        check_val("released", 12'hFFF, {data_oe_n, rd_oe_n, wr_oe_n, addr_oe_n});
        check_val("strobe echo", 0, echo);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // About 300 cycles are needed; over sixty times that means a hang
    initial begin
        #(50 * 20000);
        failures++;
        print_verdict();
    end

    initial begin
        sys_rst = 1'b1;
        dma_ctl = '0;
        inta_active = 1'b0;
        inta_vector = 8'h00;
        host_rd_data = 8'h00;
        rtc_idx = 8'h00;
        rnd = 32'hDFCB7F55;
        failures = 0;
        check_count = 0;
        repeat (10) @(negedge sys_clk);
        check_val("reset pins", 16'hFFFC, {data_oe_n, rd_oe_n, wr_oe_n, addr_oe_n, rd_out,
                  wr_out, stb_byte, stb_word});
        check_val("reset regs", 0, {host_req, temp_data, data_out} | addr_out);
        sys_rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        end_test("reset");
        foreach (addrs[i]) begin
            roll();
            host_access(rnd[0], addrs[i], rnd[15:8], 1'b1);
        end
        repeat (6) begin
            roll();
            host_access(rnd[1], rnd[25:16], rnd[15:8], 1'b1);
        end
        end_test("decode");
        host_access(1'b1, 10'h070, 8'h3C, 1'b1);
        host_access(1'b0, 10'h071, 8'hC3, 1'b1);
        end_test("clock ram");
        dma_check(1'b0, 1'b1);
        dma_check(1'b1, 1'b0);
        end_test("dma");
        roll();
        i_host.mem_data(1'b1, rnd[7:0]);
        dma_ctl.own = 1'b1;
        dma_ctl.m2m_cap = 1'b1;
        repeat (4) @(negedge sys_clk);
        dma_ctl.m2m_cap = 1'b0;
        i_host.mem_data(1'b0, 8'h00);
        @(negedge sys_clk);
        check_val("temp", rnd[7:0], temp_data);
        dma_ctl.m2m_drive = 1'b1;
        dma_ctl.drive_hi = 1'b1;
        dma_ctl.addr_hi = ~rnd[7:0];
        @(negedge sys_clk);
        check_val("temp out", {1'b0, rnd[7:0]}, {data_oe_n, data_level});
        dma_ctl = '0;
        end_test("memory to memory");
        roll();
        inta_vector = rnd[7:0];
        inta_active = 1'b1;
        repeat (2) @(negedge sys_clk);
        check_val("vector", {1'b0, rnd[7:0]}, {data_oe_n, data_level});
        host_access(1'b0, 10'h022, rnd[15:8], 1'b0);
        check_val("vector held", rnd[7:0], data_level);
        inta_active = 1'b0;
        end_test("interrupt acknowledge");
        print_verdict();
    end
endmodule // xbus_host_port_bench
